// ---- call_stack_skip_alu_core_test.sv ----
// self-checking testbench of the call stack, skip and alu core
`timescale 1ns/1ns
`default_nettype none
module call_stack_skip_alu_core_test;
    import csa_pkg::*;

    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic instr_valid = 1'b0;
    csa_op_t instr_op = OP_NOP;
    logic [7:0] instr_file = 8'h00;
    logic [2:0] instr_bit = 3'h0;
    logic [8:0] instr_lit = 9'h000;
    logic instr_to_w = 1'b0;
    logic power_down_flag = 1'b0;
    logic watchdog_timeout_flag = 1'b0;
    logic [PC_W-1:0] fetch_addr;
    logic [DATA_W-1:0] w_reg;
    logic [DATA_W-1:0] cpu_flags;
    logic [DATA_W-1:0] file_select_pointer;
    logic [DATA_W-1:0] option_reg;
    logic skip_active;
    int n_fail = 0;
    int checked = 0;
    logic [PC_W-1:0] ret [9];
    csa_op_t lg_op [3] = '{OP_AND, OP_OR, OP_XOR};
    logic [7:0] lg_exp [3] = '{8'h24, 8'hBD, 8'h99};
    csa_op_t sk_op [5] = '{OP_DECREMENT_SKIP_ZERO, OP_INCREMENT_SKIP_ZERO,
        OP_SKIP_IF_BIT_CLEAR, OP_SKIP_IF_BIT_SET, OP_SKIP_IF_BIT_SET};
    logic [7:0] sk_f [5] = '{8'h30, 8'h31, 8'h30, 8'h32, 8'h30};
    logic [2:0] sk_b [5] = '{3'h0, 3'h0, 3'h3, 3'h7, 3'h0};
    logic sk_hit [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

    csa_core uut (
        .CLK_SYS(clk_sys),
        .RST(rst),
        .INSTR_VALID(instr_valid),
        .INSTR_OP(instr_op),
        .INSTR_FILE(instr_file),
        .INSTR_BIT(instr_bit),
        .INSTR_LIT(instr_lit),
        .INSTR_TO_W(instr_to_w),
        .POWER_DOWN_FLAG(power_down_flag),
        .WATCHDOG_TIMEOUT_FLAG(watchdog_timeout_flag),
        .FETCH_ADDR(fetch_addr),
        .W_REG(w_reg),
        .CPU_FLAGS(cpu_flags),
        .FILE_SELECT_POINTER(file_select_pointer),
        .OPTION_REG(option_reg),
        .SKIP_ACTIVE(skip_active)
    );

    initial begin
        forever #4 clk_sys = ~clk_sys;
    end

    // ---------------------------------------------------------------
    // instruction and compare tasks
    // ---------------------------------------------------------------
    task automatic exec(input csa_op_t op, input logic [7:0] f, input logic [2:0] b,
                        input logic [8:0] lit, input logic tw);
        instr_valid = 1'b1;
        instr_op = op;
        instr_file = f;
        instr_bit = b;
        instr_lit = lit;
        instr_to_w = tw;
        @(posedge clk_sys);
        #1;
    endtask : exec

    task automatic opf(input csa_op_t op, input logic [7:0] f, input logic tw);
        exec(op, f, 3'h0, 9'h000, tw);
    endtask : opf

    task automatic setw(input logic [7:0] v);
        exec(OP_MOV_LIT_W, 8'h00, 3'h0, {1'b0, v}, 1'b0);
    endtask : setw

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        setw(v);
        opf(OP_MOV_W_FILE, a, 1'b0);
    endtask : wr

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: data got %h expected %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk_pc(input logic [11:0] got, input logic [11:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: fetch address got %h expected %h", $time, got, exp);
        end
    endtask : chk_pc

    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: flag got %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        opf(OP_MOV_FILE_W, a, 1'b1);
        chk8(w_reg, exp);
    endtask : rd

    task automatic finish_test;
        if (n_fail == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        #(8 * 3000);
        n_fail++;
        $display("ERROR %0t: watchdog expired", $time);
        finish_test();
    end

    // ---------------------------------------------------------------
    // test sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        chk_pc(fetch_addr, 12'h000);
        chk8(w_reg, 8'h00);
        chk8(option_reg, 8'hFF);
        chk8(cpu_flags, 8'h00);
        chk_bit(skip_active, 1'b0);
        // status inputs mirrored, bits not writable
        power_down_flag = 1'b1;
        opf(OP_NOP, 8'h00, 1'b0);
        chk8(cpu_flags, 8'h08);
        power_down_flag = 1'b0;
        watchdog_timeout_flag = 1'b1;
        opf(OP_NOP, 8'h00, 1'b0);
        chk8(cpu_flags, 8'h10);
        watchdog_timeout_flag = 1'b0;
        wr(8'h03, 8'hFF);
        chk8(cpu_flags, 8'hE7);
        rd(8'h03, 8'hE7);
        wr(8'h03, 8'h00);
        wr(8'h04, 8'h5A);
        chk8(file_select_pointer, 8'h5A);
        exec(OP_JMP, 8'h00, 3'h0, 9'h1F0, 1'b0);
        rd(8'h02, 8'hF0);
        wr(8'h02, 8'h80);
        chk8(fetch_addr[7:0], 8'h80);
        setw(8'h3C);
        opf(OP_LOAD_OPTION, 8'h00, 1'b0);
        chk8(option_reg, 8'h3C);
        wr(8'hFF, 8'h6B);
        wr(8'h10, 8'h21);
        rd(8'hFF, 8'h6B);
        chk8(option_reg, 8'h3C);
        wr(8'h04, 8'h10);
        rd(8'h00, 8'h21);
        // logic ops, last one indirect
        wr(8'h20, 8'h3C);
        wr(8'h04, 8'h20);
        for (int i = 0; i < 3; i++) begin
            setw(8'hA5);
            opf(lg_op[i], (i == 2) ? 8'h00 : 8'h20, 1'b1);
            chk8(w_reg, lg_exp[i]);
        end
        setw(8'h42);
        opf(OP_AND, 8'h20, 1'b1);
        chk_bit(cpu_flags[2], 1'b1);
        // rotates through carry
        wr(8'h03, 8'h00);
        wr(8'h21, 8'h80);
        opf(OP_ROT_LEFT, 8'h21, 1'b1);
        chk8(w_reg, 8'h00);
        chk_bit(cpu_flags[0], 1'b1);
        opf(OP_ROT_RIGHT, 8'h21, 1'b0);
        chk_bit(cpu_flags[0], 1'b0);
        rd(8'h21, 8'hC0);
        setw(8'h5A);
        opf(OP_NOT_W, 8'h00, 1'b1);
        chk8(w_reg, 8'hA5);
        opf(OP_NOT_FILE, 8'h21, 1'b0);
        rd(8'h21, 8'h3F);
        opf(OP_SWAP_TO_W, 8'h21, 1'b1);
        chk8(w_reg, 8'hF3);
        // skip conditions, last one false
        wr(8'h30, 8'h01);
        wr(8'h31, 8'hFF);
        wr(8'h32, 8'h80);
        for (int i = 0; i < 5; i++) begin
            setw(8'h11);
            exec(sk_op[i], sk_f[i], sk_b[i], 9'h000, 1'b0);
            chk_bit(skip_active, sk_hit[i]);
            setw(8'h77);
            chk8(w_reg, sk_hit[i] ? 8'h11 : 8'h77);
            chk_bit(skip_active, 1'b0);
        end
        // prefix chain after a true skip
        setw(8'h11);
        exec(OP_JMP, 8'h00, 3'h0, 9'h050, 1'b0);
        exec(OP_SKIP_IF_BIT_SET, 8'h32, 3'h7, 9'h000, 1'b0);
        exec(OP_PAGE, 8'h00, 3'h0, 9'h003, 1'b0);
        chk_bit(skip_active, 1'b1);
        exec(OP_BANK, 8'h00, 3'h0, 9'h002, 1'b0);
        chk_bit(skip_active, 1'b1);
        setw(8'h77);
        chk_pc(fetch_addr, 12'h054);
        chk8(w_reg, 8'h11);
        chk8(file_select_pointer, 8'h20);
        chk8(cpu_flags & 8'hE0, 8'h00);
        // nine calls overflow, nine returns
        exec(OP_JMP, 8'h00, 3'h0, 9'h100, 1'b0);
        for (int i = 0; i < 9; i++) begin
            ret[i] = (i == 0) ? 12'h101 : 12'(16 * i + 1);
            exec(OP_CALL, 8'h00, 3'h0, 9'(16 * (i + 1)), 1'b0);
            chk_pc(fetch_addr, 12'(16 * (i + 1)));
        end
        for (int k = 0; k < 9; k++) begin
            exec(OP_RET, 8'h00, 3'h0, 9'h000, 1'b0);
            chk_pc(fetch_addr, ret[(k < 8) ? 8 - k : 1]);
        end
        // page-restoring return
        exec(OP_PAGE, 8'h00, 3'h0, 9'h005, 1'b0);
        chk8(cpu_flags & 8'hE0, 8'hA0);
        exec(OP_JMP, 8'h00, 3'h0, 9'h1AB, 1'b0);
        chk_pc(fetch_addr, 12'hBAB);
        exec(OP_CALL, 8'h00, 3'h0, 9'h122, 1'b0);
        chk_pc(fetch_addr, 12'hA22);
        exec(OP_PAGE, 8'h00, 3'h0, 9'h000, 1'b0);
        exec(OP_RETURN_RESTORE_PAGE, 8'h00, 3'h0, 9'h000, 1'b0);
        chk_pc(fetch_addr, 12'hBAC);
        chk8(cpu_flags & 8'hE0, 8'hA0);
        instr_valid = 1'b0;
        finish_test();
    end

endmodule : call_stack_skip_alu_core_test
`default_nettype wire

// ---- csa_alu.sv ----
// logic, rotate, complement, swap and count datapath
`timescale 1ns/1ns
`default_nettype none
module csa_alu (
    input wire csa_pkg::csa_op_t op,
    input wire logic [csa_pkg::DATA_W-1:0] operand,
    input wire logic [csa_pkg::DATA_W-1:0] w,
    input wire logic carry_in,
    output logic [csa_pkg::DATA_W-1:0] result,
    output logic carry_out,
    output logic zero
);
    import csa_pkg::*;

    always_comb begin
        result = operand;
        carry_out = carry_in;
        unique case (op)
            OP_AND: result = w & operand;
            OP_OR: result = w | operand;
            OP_XOR: result = w ^ operand;
            OP_ROT_LEFT: begin
                result = {operand[6:0], carry_in};
                carry_out = operand[7];
            end
            OP_ROT_RIGHT: begin
                result = {carry_in, operand[7:1]};
                carry_out = operand[0];
            end
            OP_NOT_FILE: result = ~operand;
            OP_NOT_W: result = ~w;
            OP_SWAP_TO_W: result = {operand[3:0], operand[7:4]};
            OP_DECREMENT_SKIP_ZERO: result = operand - 8'h01;
            OP_INCREMENT_SKIP_ZERO: result = operand + 8'h01;
            OP_MOV_W_FILE: result = w;
            default: result = operand;
        endcase
        zero = (result == 8'h00);
    end

endmodule : csa_alu
`default_nettype wire

// ---- csa_core.sv ----
// core control: program counter, flags, file space, skip sequencing
`timescale 1ns/1ns
`default_nettype none
module csa_core (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic INSTR_VALID,
    input wire csa_pkg::csa_op_t INSTR_OP,
    input wire logic [7:0] INSTR_FILE,
    input wire logic [2:0] INSTR_BIT,
    input wire logic [8:0] INSTR_LIT,
    input wire logic INSTR_TO_W,
    input wire logic POWER_DOWN_FLAG,
    input wire logic WATCHDOG_TIMEOUT_FLAG,
    output logic [csa_pkg::PC_W-1:0] FETCH_ADDR,
    output logic [csa_pkg::DATA_W-1:0] W_REG,
    output logic [csa_pkg::DATA_W-1:0] CPU_FLAGS,
    output logic [csa_pkg::DATA_W-1:0] FILE_SELECT_POINTER,
    output logic [csa_pkg::DATA_W-1:0] OPTION_REG,
    output logic SKIP_ACTIVE
);
    import csa_pkg::*;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [PC_W-1:0] pc;
        logic [DATA_W-1:0] w;
        logic [DATA_W-1:0] sel_ptr;
        logic [DATA_W-1:0] option;
        logic [PAGE_W-1:0] page;
        logic c;
        logic dig_c;
        logic z;
        logic pwr_dn;
        logic wd_timeout;
        logic skip;
    } csa_core_t;

    csa_core_t q, d;

    logic [DATA_W-1:0] ram_q [0:255];
    logic ram_we;
    logic [7:0] eff_addr;
    logic [DATA_W-1:0] operand;
    logic [DATA_W-1:0] flags_view;
    logic [DATA_W-1:0] alu_res;
    logic alu_c;
    logic alu_z;
    logic push;
    logic pop;
    logic wr_file;
    logic exec;
    logic [PC_W-1:0] pc_inc;
    logic [PC_W-1:0] stack_top;

    // ---------------------------------------------------------------
    // file space decode
    // ---------------------------------------------------------------
    assign exec = INSTR_VALID && !q.skip;
    assign pc_inc = q.pc + 12'h001;
    assign flags_view = {q.page, q.wd_timeout, q.pwr_dn, q.z, q.dig_c, q.c};

    always_comb begin
        // address 00h goes through the pointer
        eff_addr = (INSTR_FILE == INDIRECT_OPERAND_ADDR) ? q.sel_ptr : INSTR_FILE;
        unique case (eff_addr)
            INDIRECT_OPERAND_ADDR: operand = 8'h00;
            PROGRAM_COUNTER_LOW_ADDR: operand = q.pc[7:0];
            CPU_FLAGS_ADDR: operand = flags_view;
            FILE_SELECT_POINTER_ADDR: operand = q.sel_ptr;
            default: operand = ram_q[eff_addr];
        endcase
    end

    csa_alu u_alu (
        .op(INSTR_OP),
        .operand(operand),
        .w(q.w),
        .carry_in(q.c),
        .result(alu_res),
        .carry_out(alu_c),
        .zero(alu_z)
    );

    csa_return_stack u_stack (
        .clk(CLK_SYS),
        .rst(RST),
        .push(push),
        .pop(pop),
        .push_addr(pc_inc),
        .top(stack_top)
    );

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        d = q;
        push = 1'b0;
        pop = 1'b0;
        wr_file = 1'b0;
        ram_we = 1'b0;
        d.pwr_dn = POWER_DOWN_FLAG;
        d.wd_timeout = WATCHDOG_TIMEOUT_FLAG;
        if (INSTR_VALID && q.skip) begin
            // annulled slot; prefixes keep the skip alive
            d.pc = pc_inc;
            d.skip = (INSTR_OP == OP_PAGE) || (INSTR_OP == OP_BANK);
        end else if (exec) begin
            d.pc = pc_inc;
            unique case (INSTR_OP)
                OP_NOP: ;
                OP_CALL: begin
                    push = 1'b1;
                    d.pc = {q.page, 1'b0, INSTR_LIT[7:0]};
                end
                OP_JMP: d.pc = {q.page, INSTR_LIT};
                OP_RET: begin
                    pop = 1'b1;
                    d.pc = stack_top;
                end
                OP_RETURN_RESTORE_PAGE: begin
                    pop = 1'b1;
                    d.pc = stack_top;
                    d.page = stack_top[PC_W-1:PC_W-PAGE_W];
                end
                OP_PAGE: d.page = INSTR_LIT[PAGE_W-1:0];
                OP_BANK: d.sel_ptr[7:BANK_LSB] = INSTR_LIT[PAGE_W-1:0];
                OP_MOV_LIT_W: d.w = INSTR_LIT[7:0];
                OP_LOAD_OPTION: d.option = q.w;
                OP_MOV_W_FILE: wr_file = 1'b1;
                OP_MOV_FILE_W: begin
                    d.w = operand;
                    d.z = alu_z;
                end
                OP_AND, OP_OR, OP_XOR, OP_NOT_FILE: begin
                    d.z = alu_z;
                    if (INSTR_TO_W) begin
                        d.w = alu_res;
                    end else begin
                        wr_file = 1'b1;
                    end
                end
                OP_ROT_LEFT, OP_ROT_RIGHT: begin
                    d.c = alu_c;
                    if (INSTR_TO_W) begin
                        d.w = alu_res;
                    end else begin
                        wr_file = 1'b1;
                    end
                end
                OP_NOT_W: begin
                    d.w = alu_res;
                    d.z = alu_z;
                end
                OP_SWAP_TO_W: d.w = alu_res;
                OP_DECREMENT_SKIP_ZERO, OP_INCREMENT_SKIP_ZERO: begin
                    wr_file = 1'b1;
                    d.skip = alu_z;
                end
                OP_SKIP_IF_BIT_CLEAR: d.skip = !operand[INSTR_BIT];
                OP_SKIP_IF_BIT_SET: d.skip = operand[INSTR_BIT];
                default: ;
            endcase
            if (wr_file) begin
                unique case (eff_addr)
                    INDIRECT_OPERAND_ADDR: ;
                    PROGRAM_COUNTER_LOW_ADDR: d.pc[7:0] = alu_res;
                    CPU_FLAGS_ADDR: begin
                        // power down and timeout bits are read only
                        d.c = alu_res[CARRY_BIT];
                        d.dig_c = alu_res[DIGIT_CARRY_BIT];
                        d.z = alu_res[ZERO_BIT];
                        d.page = alu_res[PAGE_MSB:PAGE_LSB];
                    end
                    FILE_SELECT_POINTER_ADDR: d.sel_ptr = alu_res;
                    default: ram_we = 1'b1;
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            q <= '{pc: PC_RESET, w: W_RESET, sel_ptr: FILE_SELECT_POINTER_RESET,
                   option: OPTION_RESET, page: PAGE_RESET, c: 1'b0, dig_c: 1'b0,
                   z: 1'b0, pwr_dn: 1'b0, wd_timeout: 1'b0, skip: 1'b0};
        end else begin
            q <= d;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (ram_we) begin
            ram_q[eff_addr] <= alu_res;
        end
    end

    assign FETCH_ADDR = q.pc;
    assign W_REG = q.w;
    assign CPU_FLAGS = flags_view;
    assign FILE_SELECT_POINTER = q.sel_ptr;
    assign OPTION_REG = q.option;
    assign SKIP_ACTIVE = q.skip;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    property p_ret_pc;
        @(posedge CLK_SYS) disable iff (RST)
            (exec && (INSTR_OP == OP_RET)) |=> q.pc == $past(stack_top);
    endproperty
    a_ret_pc: assert property (p_ret_pc) else $error("return pc not stack top");

    property p_call_ret;
        @(posedge CLK_SYS) disable iff (RST)
            (exec && (INSTR_OP == OP_CALL)) ##1 (exec && (INSTR_OP == OP_RET))
            |=> q.pc == ($past(q.pc, 2) + 12'h001);
    endproperty
    a_call_ret: assert property (p_call_ret) else $error("call then return wrong");

    property p_skip_set;
        @(posedge CLK_SYS) disable iff (RST)
            (exec && (INSTR_OP == OP_SKIP_IF_BIT_SET) && operand[INSTR_BIT]) |=> q.skip;
    endproperty
    a_skip_set: assert property (p_skip_set) else $error("bit set skip missed");

    property p_prefix_chain;
        @(posedge CLK_SYS) disable iff (RST)
            (INSTR_VALID && q.skip && ((INSTR_OP == OP_PAGE) || (INSTR_OP == OP_BANK)))
            |=> q.skip && (q.page == $past(q.page)) && (q.sel_ptr == $past(q.sel_ptr));
    endproperty
    a_prefix_chain: assert property (p_prefix_chain) else $error("prefix not skipped");

    property p_skip_end;
        @(posedge CLK_SYS) disable iff (RST)
            (INSTR_VALID && q.skip && (INSTR_OP != OP_PAGE) && (INSTR_OP != OP_BANK))
            |=> !q.skip && (q.w == $past(q.w));
    endproperty
    a_skip_end: assert property (p_skip_end) else $error("skip did not end");

    property p_rotate_carry;
        @(posedge CLK_SYS) disable iff (RST)
            (exec && (INSTR_OP == OP_ROT_LEFT) && INSTR_TO_W) |=> q.c == $past(operand[7]);
    endproperty
    a_rotate_carry: assert property (p_rotate_carry) else $error("rotate carry wrong");

    property p_flags_view;
        @(posedge CLK_SYS) disable iff (RST)
            1'b1 |=> CPU_FLAGS[POWER_DOWN_BIT] == $past(POWER_DOWN_FLAG)
                && CPU_FLAGS[WATCHDOG_TIMEOUT_BIT] == $past(WATCHDOG_TIMEOUT_FLAG);
    endproperty
    a_flags_view: assert property (p_flags_view) else $error("status flags misplaced");

    property p_call_pc;
        @(posedge CLK_SYS) disable iff (RST)
            (exec && (INSTR_OP == OP_CALL))
            |=> q.pc == {$past(q.page), 1'b0, $past(INSTR_LIT[7:0])};
    endproperty
    a_call_pc: assert property (p_call_pc) else $error("call target wrong");

    property p_page_cmd;
        @(posedge CLK_SYS) disable iff (RST)
            (exec && (INSTR_OP == OP_PAGE)) |=> q.page == $past(INSTR_LIT[PAGE_W-1:0]);
    endproperty
    a_page_cmd: assert property (p_page_cmd) else $error("page select not loaded");

    property p_return_restore_page_page;
        @(posedge CLK_SYS) disable iff (RST)
            (exec && (INSTR_OP == OP_RETURN_RESTORE_PAGE))
            |=> q.page == $past(stack_top[PC_W-1:PC_W-PAGE_W]);
    endproperty
    a_return_restore_page_page: assert property (p_return_restore_page_page) else $error("page not restored");

    property p_skip_clear;
        @(posedge CLK_SYS) disable iff (RST)
            (exec && (INSTR_OP == OP_SKIP_IF_BIT_CLEAR) && !operand[INSTR_BIT]) |=> q.skip;
    endproperty
    a_skip_clear: assert property (p_skip_clear) else $error("bit clear skip missed");

    property p_annul_pc;
        @(posedge CLK_SYS) disable iff (RST)
            (INSTR_VALID && q.skip) |=> q.pc == ($past(q.pc) + 12'h001);
    endproperty
    a_annul_pc: assert property (p_annul_pc) else $error("annulled slot pc wrong");

    property p_option_hold;
        @(posedge CLK_SYS) disable iff (RST)
            !(exec && (INSTR_OP == OP_LOAD_OPTION)) |=> q.option == $past(q.option);
    endproperty
    a_option_hold: assert property (p_option_hold) else $error("option changed");

    property p_fsp_write;
        @(posedge CLK_SYS) disable iff (RST)
            (wr_file && (eff_addr == FILE_SELECT_POINTER_ADDR)) |=> q.sel_ptr == $past(alu_res);
    endproperty
    a_fsp_write: assert property (p_fsp_write) else $error("pointer write lost");

    property p_swap;
        @(posedge CLK_SYS) disable iff (RST)
            (exec && (INSTR_OP == OP_SWAP_TO_W))
            |=> q.w == {$past(operand[3:0]), $past(operand[7:4])};
    endproperty
    a_swap: assert property (p_swap) else $error("nibble swap wrong");

endmodule : csa_core
`default_nettype wire

// ---- csa_pkg.sv ----
// constants, types and opcode set of the call stack, skip and alu core
package csa_pkg;

    localparam int DATA_W = 8;
    localparam int PC_W = 12;
    localparam int PAGE_W = 3;
    localparam int STACK_DEPTH = 8;

    // ---------------------------------------------------------------
    // file register map
    // ---------------------------------------------------------------
    localparam logic [7:0] INDIRECT_OPERAND_ADDR = 8'h00;
    localparam logic [7:0] PROGRAM_COUNTER_LOW_ADDR = 8'h02;
    localparam logic [7:0] CPU_FLAGS_ADDR = 8'h03;
    localparam logic [7:0] FILE_SELECT_POINTER_ADDR = 8'h04;

    // ---------------------------------------------------------------
    // cpu_flags fields
    // ---------------------------------------------------------------
    localparam int CARRY_BIT = 0;
    localparam int DIGIT_CARRY_BIT = 1;
    localparam int ZERO_BIT = 2;
    localparam int POWER_DOWN_BIT = 3;
    localparam int WATCHDOG_TIMEOUT_BIT = 4;
    localparam int PAGE_LSB = 5;
    localparam int PAGE_MSB = 7;
    localparam int BANK_LSB = 5;

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [PC_W-1:0] PC_RESET = 12'h000;
    localparam logic [7:0] W_RESET = 8'h00;
    localparam logic [7:0] FILE_SELECT_POINTER_RESET = 8'h00;
    localparam logic [7:0] OPTION_RESET = 8'hFF;
    localparam logic [PAGE_W-1:0] PAGE_RESET = 3'h0;

    typedef enum logic [4:0] {
        OP_NOP = 5'h00,
        OP_CALL = 5'h01,
        OP_JMP = 5'h02,
        OP_RET = 5'h03,
        OP_RETURN_RESTORE_PAGE = 5'h04,
        OP_PAGE = 5'h05,
        OP_BANK = 5'h06,
        OP_MOV_LIT_W = 5'h07,
        OP_LOAD_OPTION = 5'h08,
        OP_MOV_W_FILE = 5'h09,
        OP_MOV_FILE_W = 5'h0A,
        OP_AND = 5'h0B,
        OP_OR = 5'h0C,
        OP_XOR = 5'h0D,
        OP_ROT_LEFT = 5'h0E,
        OP_ROT_RIGHT = 5'h0F,
        OP_NOT_FILE = 5'h10,
        OP_NOT_W = 5'h11,
        OP_SWAP_TO_W = 5'h12,
        OP_DECREMENT_SKIP_ZERO = 5'h13,
        OP_INCREMENT_SKIP_ZERO = 5'h14,
        OP_SKIP_IF_BIT_CLEAR = 5'h15,
        OP_SKIP_IF_BIT_SET = 5'h16
    } csa_op_t;

endpackage : csa_pkg

// ---- csa_return_stack.sv ----
// eight-level hardware return-address stack
`timescale 1ns/1ns
`default_nettype none
module csa_return_stack (
    input wire logic clk,
    input wire logic rst,
    input wire logic push,
    input wire logic pop,
    input wire logic [csa_pkg::PC_W-1:0] push_addr,
    output logic [csa_pkg::PC_W-1:0] top
);
    import csa_pkg::*;

    typedef struct packed {
        logic [STACK_DEPTH-1:0][PC_W-1:0] lvl;
    } csa_stack_t;

    csa_stack_t q, d;

    always_comb begin
        d = q;
        if (push) begin
            // deepest entry falls off the end
            for (int i = STACK_DEPTH - 1; i > 0; i--) begin
                d.lvl[i] = q.lvl[i-1];
            end
            d.lvl[0] = push_addr;
        end else if (pop) begin
            for (int i = 0; i < STACK_DEPTH - 1; i++) begin
                d.lvl[i] = q.lvl[i+1];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign top = q.lvl[0];

    property p_push_top;
        @(posedge clk) disable iff (rst) push |=> top == $past(push_addr);
    endproperty
    a_push_top: assert property (p_push_top) else $error("push lost address");

    property p_push_deep;
        @(posedge clk) disable iff (rst) push |=> q.lvl[7] == $past(q.lvl[6]);
    endproperty
    a_push_deep: assert property (p_push_deep) else $error("level 8 not from 7");

    property p_pop_keep;
        @(posedge clk) disable iff (rst)
            (pop && !push) |=> (q.lvl[7] == $past(q.lvl[7])) && (q.lvl[6] == $past(q.lvl[7]));
    endproperty
    a_pop_keep: assert property (p_pop_keep) else $error("pop deep level wrong");

endmodule : csa_return_stack
`default_nettype wire
